// [rtl/ursi_pkg.sv]
// Package of constants for the receive status and interrupt block
// Notes on behaviour
// [RQ1] With threshold 11 the receive interrupt fires when a transfer makes the buffer hold 4.
// [RQ2] With threshold 10 the receive interrupt fires when a transfer makes the buffer hold 3.
// [RQ3] With threshold 0x the receive interrupt fires on every transfer into the buffer.
// [RQ4] Address detect marks ninth-bit-one characters as addresses, only in 9-bit mode.
// [RQ5] The receiver idle flag reads one when idle and zero while a character arrives.
// [RQ6] The parity error flag shows the parity status of the character at the buffer top.
// [RQ7] The framing error flag shows the framing status of the character at the buffer top.
// [RQ8] The overrun flag sets when the buffer overflows and stays set until software clears it.
// [RQ9] Clearing a set overrun flag empties the receive buffer and the shift register.
// [RQ10] The data available flag is one whenever the buffer holds at least one character.
// [RQ11] While overrun is set, newly completed characters are dropped and the buffer is kept.
// [RQ12] Parity and framing flags follow each character as reads advance the buffer.
package ursi_pkg;
	// ************************************************
	// Register map
	// ************************************************
	localparam logic [7:0] ADDR_STATUS   = 8'h00;
	localparam logic [7:0] ADDR_DATA     = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
	localparam logic [7:0] ADDR_IRQ_EN   = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_CLR  = 8'h10;
	localparam logic [7:0] ADDR_CTRL     = 8'h14;
	// ************************************************
	// Status fields
	// ************************************************
	localparam int BIT_DA     = 0;
	localparam int BIT_OVERRUN_ERROR_FLAG   = 1;
	localparam int BIT_FRAMING_ERROR_FLAG   = 2;
	localparam int BIT_PARITY_ERROR_FLAG   = 3;
	localparam int BIT_IDLE   = 4;
	localparam int BIT_ADDRESS_DETECT_ENABLE  = 5;
	localparam int BIT_THR_LO = 6;
	localparam int BIT_THR_HI = 7;
	localparam int BIT_NINE   = 0;
	localparam int DATA_W     = 9;
	localparam int DATA_ADDR  = 9;
	localparam int DATA_PARITY_ERROR_FLAG  = 10;
	localparam int DATA_FRAMING_ERROR_FLAG  = 11;
	localparam int IRQ_RX     = 0;
	localparam int IRQ_OVR    = 1;
	localparam int IRQ_W      = 2;
	localparam int FIFO_DEPTH = 4;
	localparam logic [1:0] THR_FULL  = 2'h3;
	localparam logic [1:0] THR_3Q    = 2'h2;
	localparam logic [2:0] LVL_FULL  = 3'h4;
	localparam logic [2:0] LVL_3Q    = 3'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLV  = 2'h2;
endpackage

// [rtl/ursi_fifo.sv]
// Receive character buffer with per-character error bits
`timescale 1ns/1ps
module ursi_fifo #(
	parameter int W     = 12,
	parameter int DEPTH = 4
) (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic          flush,
	input  wire logic          push,
	input  wire logic [W-1:0]  push_data,
	input  wire logic          pop,
	output logic [W-1:0]       top_data,
	output logic [2:0]         level
);
	logic [W-1:0] mem [DEPTH];
	logic [1:0]   rd_ptr;
	logic [1:0]   wr_ptr;

	// Pushes when full are refused by the caller, not here
	always_ff @(posedge aclk) begin
		if (!aresetn || flush) begin
			rd_ptr <= 2'h0;
			wr_ptr <= 2'h0;
			level  <= 3'h0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 2'h1;
			if (pop)
				rd_ptr <= rd_ptr + 2'h1;
			level <= level + {2'h0, push} - {2'h0, pop};
		end
	end

	always_ff @(posedge aclk) begin
		if (push)
			mem[wr_ptr] <= push_data;
	end

	assign top_data = (level == 3'h0) ? '0 : mem[rd_ptr];
endmodule

// [rtl/ursi_top.sv]
// Receive status, error flags and interrupt selection behind AXI4-Lite
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module ursi_top #(
	parameter int DEPTH = 4
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        rx_busy,
	input  wire logic        rx_done,
	input  wire logic [8:0]  rx_char,
	input  wire logic        rx_parity_error_flag,
	input  wire logic        rx_framing_error_flag,
	output logic             rx_flush,
	output logic             irq
);
	// ************************************************
	// State
	// ************************************************
	logic [1:0]  receive_irq_threshold;
	logic        address_detect_enable;
	logic        nine_bit_mode;
	logic        overrun_error_flag;
	logic [1:0]  irq_stat;
	logic [1:0]  irq_en;
	logic        busy_s1;
	logic        busy_s2;
	logic [11:0] top_data;
	logic [2:0]  level;
	logic        push;
	logic        pop;
	logic        flush;
	logic        overflow;
	logic        rx_event;
	logic        is_addr;
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        do_write;
	logic        do_read;
	logic [31:0] status_word;
	logic        receiver_idle_flag;
	logic        receive_data_available;

	// ************************************************
	// Receiver side
	// ************************************************
	// Busy level comes from the serial front end on another timing path
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_s1 <= 1'b0;
			busy_s2 <= 1'b0;
		end else begin
			busy_s1 <= rx_busy;
			busy_s2 <= busy_s1;
		end
	end

	assign receiver_idle_flag = !busy_s2; // RQ5
	assign is_addr = address_detect_enable && nine_bit_mode && rx_char[8]; // RQ4
	// A read in the same cycle frees a slot, so a full buffer still takes the character
	assign push = rx_done && !overrun_error_flag && (level < 3'(DEPTH) || pop); // RQ11
	assign overflow = rx_done && !overrun_error_flag && (level == 3'(DEPTH)) && !pop; // RQ8
	assign receive_data_available = (level != 3'h0); // RQ10

	function automatic logic [2:0] fill_after(input logic [2:0] lv, input logic popped);
		return lv + 3'h1 - {2'h0, popped};
	endfunction

	// With threshold 1x the fill level after this transfer decides the interrupt; with 0x every transfer fires it
	always_comb begin
		rx_event = 1'b0;
		if (push) begin
			case (receive_irq_threshold)
				ursi_pkg::THR_FULL: rx_event = (fill_after(level, pop) == ursi_pkg::LVL_FULL); // RQ1
				ursi_pkg::THR_3Q:   rx_event = (fill_after(level, pop) == ursi_pkg::LVL_3Q); // RQ2
				default:            rx_event = 1'b1; // RQ3
			endcase
		end
	end

	ursi_fifo #(
		.W     (12),
		.DEPTH (DEPTH)
	) u_fifo (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.flush     (flush),
		.push      (push),
		.push_data ({rx_framing_error_flag, rx_parity_error_flag, is_addr, rx_char}),
		.pop       (pop),
		.top_data  (top_data),
		.level     (level)
	);

	assign rx_flush = flush;

	// ************************************************
	// Control and flags
	// ************************************************
	// Overrun clear is a write of zero to the status bit while it is set
	assign flush = do_write && (aw_addr == ursi_pkg::ADDR_STATUS) && w_strb[0]
		&& overrun_error_flag && !w_data[ursi_pkg::BIT_OVERRUN_ERROR_FLAG]; // RQ9

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			overrun_error_flag <= 1'b0;
		end else if (overflow) begin
			overrun_error_flag <= 1'b1; // RQ8
		end else if (flush) begin
			overrun_error_flag <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			receive_irq_threshold <= 2'h0;
			address_detect_enable <= 1'b0;
			nine_bit_mode         <= 1'b0;
			irq_en                <= 2'h0;
		end else if (do_write && w_strb[0]) begin
			if (aw_addr == ursi_pkg::ADDR_STATUS) begin
				receive_irq_threshold <= w_data[ursi_pkg::BIT_THR_HI:ursi_pkg::BIT_THR_LO];
				address_detect_enable <= w_data[ursi_pkg::BIT_ADDRESS_DETECT_ENABLE];
			end else if (aw_addr == ursi_pkg::ADDR_CTRL) begin
				nine_bit_mode <= w_data[ursi_pkg::BIT_NINE];
			end else if (aw_addr == ursi_pkg::ADDR_IRQ_EN) begin
				irq_en <= w_data[ursi_pkg::IRQ_W-1:0];
			end
		end
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat <= 2'h0;
		end else begin
			for (int i = 0; i < ursi_pkg::IRQ_W; i++) begin
				if ((i == ursi_pkg::IRQ_RX && rx_event) || (i == ursi_pkg::IRQ_OVR && overflow))
					irq_stat[i] <= 1'b1;
				else if (do_write && w_strb[0] && aw_addr == ursi_pkg::ADDR_IRQ_CLR
					&& w_data[i])
					irq_stat[i] <= 1'b0;
			end
		end
	end

	assign irq = |(irq_stat & irq_en);

	// ************************************************
	// AXI4-Lite slave
	// ************************************************
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign do_write      = aw_held && w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_read       = s_axi_arvalid && s_axi_arready;
	assign pop = do_read && (s_axi_araddr == ursi_pkg::ADDR_DATA) && receive_data_available;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (do_write) begin
				w_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= ursi_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			if (aw_addr == ursi_pkg::ADDR_STATUS || aw_addr == ursi_pkg::ADDR_IRQ_EN
				|| aw_addr == ursi_pkg::ADDR_IRQ_CLR || aw_addr == ursi_pkg::ADDR_CTRL)
				s_axi_bresp <= ursi_pkg::RESP_OKAY;
			else
				s_axi_bresp <= ursi_pkg::RESP_SLV;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_comb begin
		status_word = '0;
		status_word[ursi_pkg::BIT_THR_HI:ursi_pkg::BIT_THR_LO] = receive_irq_threshold;
		status_word[ursi_pkg::BIT_ADDRESS_DETECT_ENABLE] = address_detect_enable;
		status_word[ursi_pkg::BIT_IDLE]  = receiver_idle_flag;
		status_word[ursi_pkg::BIT_PARITY_ERROR_FLAG]  = top_data[ursi_pkg::DATA_PARITY_ERROR_FLAG]; // RQ6 RQ12
		status_word[ursi_pkg::BIT_FRAMING_ERROR_FLAG]  = top_data[ursi_pkg::DATA_FRAMING_ERROR_FLAG]; // RQ7 RQ12
		status_word[ursi_pkg::BIT_OVERRUN_ERROR_FLAG]  = overrun_error_flag;
		status_word[ursi_pkg::BIT_DA]    = receive_data_available;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= ursi_pkg::RESP_OKAY;
		end else if (do_read) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= ursi_pkg::RESP_OKAY;
			if (s_axi_araddr == ursi_pkg::ADDR_STATUS)
				s_axi_rdata <= status_word;
			else if (s_axi_araddr == ursi_pkg::ADDR_DATA)
				s_axi_rdata <= {22'h0, top_data[ursi_pkg::DATA_ADDR:0]};
			else if (s_axi_araddr == ursi_pkg::ADDR_IRQ_STAT)
				s_axi_rdata <= {30'h0, irq_stat};
			else if (s_axi_araddr == ursi_pkg::ADDR_IRQ_EN)
				s_axi_rdata <= {30'h0, irq_en};
			else if (s_axi_araddr == ursi_pkg::ADDR_IRQ_CLR)
				s_axi_rdata <= 32'h0000_0000;
			else if (s_axi_araddr == ursi_pkg::ADDR_CTRL)
				s_axi_rdata <= {31'h0, nine_bit_mode};
			else begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= ursi_pkg::RESP_SLV;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ************************************************
	// Checks
	// ************************************************
	property p_rq3_every;
		@(posedge aclk) disable iff (!aresetn)
		(push && receive_irq_threshold[1] == 1'b0) |=> irq_stat[ursi_pkg::IRQ_RX];
	endproperty
	a_rq3_every: assert property (p_rq3_every) else $error("rx irq missing"); // RQ3

	property p_rq1_full;
		@(posedge aclk) disable iff (!aresetn)
		(receive_irq_threshold == ursi_pkg::THR_FULL && rx_event) |=> level == ursi_pkg::LVL_FULL;
	endproperty
	a_rq1_full: assert property (p_rq1_full) else $error("full irq wrong level"); // RQ1

	property p_rq2_3q;
		@(posedge aclk) disable iff (!aresetn)
		(receive_irq_threshold == ursi_pkg::THR_3Q && rx_event) |=> level == ursi_pkg::LVL_3Q;
	endproperty
	a_rq2_3q: assert property (p_rq2_3q) else $error("3q irq wrong level"); // RQ2

	property p_rq8_sticky;
		@(posedge aclk) disable iff (!aresetn)
		(overrun_error_flag && !flush) |=> overrun_error_flag;
	endproperty
	a_rq8_sticky: assert property (p_rq8_sticky) else $error("overrun lost"); // RQ8

	property p_rq9_flush;
		@(posedge aclk) disable iff (!aresetn)
		flush |=> (level == 3'h0 && !overrun_error_flag);
	endproperty
	a_rq9_flush: assert property (p_rq9_flush) else $error("flush incomplete"); // RQ9

	property p_rq11_hold;
		@(posedge aclk) disable iff (!aresetn)
		(overrun_error_flag && !pop && !flush) |=> $stable(level);
	endproperty
	a_rq11_hold: assert property (p_rq11_hold) else $error("buffer changed"); // RQ11

	property p_rq10_da;
		@(posedge aclk) disable iff (!aresetn)
		push |=> receive_data_available;
	endproperty
	a_rq10_da: assert property (p_rq10_da) else $error("data available wrong"); // RQ10

	sequence s_busy_held;
		rx_busy [*3];
	endsequence

	property p_rq5_idle;
		@(posedge aclk) disable iff (!aresetn)
		s_busy_held |-> !receiver_idle_flag;
	endproperty
	a_rq5_idle: assert property (p_rq5_idle) else $error("idle while busy"); // RQ5
endmodule

// [testbench/ursi_remote_tx.sv]
// Remote serial transmitter model feeding the receive front end
`timescale 1ns/1ps
module ursi_remote_tx (
	input  wire logic  aclk,
	output logic       rx_busy,
	output logic       rx_done,
	output logic [8:0] rx_char,
	output logic       rx_parity_error_flag,
	output logic       rx_framing_error_flag
);
	// ****************************************
	// Character framing
	// ****************************************
	initial begin
		rx_busy = 1'b0;
		rx_done = 1'b0;
		rx_char = 9'h15a;
		rx_parity_error_flag = 1'b1;
		rx_framing_error_flag = 1'b0;
	end
	// Lines carry the inverse outside the pulse so a stale sample is caught
	task automatic send(input logic [8:0] ch, input logic pe, input logic fe, input int n);
		@(posedge aclk);
		rx_busy <= 1'b1;
		repeat (n) @(posedge aclk);
		rx_busy <= 1'b0;
		rx_done <= 1'b1;
		rx_char <= ch;
		rx_parity_error_flag <= pe;
		rx_framing_error_flag <= fe;
		@(posedge aclk);
		rx_done <= 1'b0;
		rx_char <= ~ch;
		rx_parity_error_flag <= ~pe;
		rx_framing_error_flag <= ~fe;
	endtask
endmodule

// [testbench/uart_receive_status_irq_bench.sv]
// Self-checking bench for the receive status and interrupt block
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module uart_receive_status_irq_bench;
	logic        aclk, aresetn, irq, rx_flush;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic        rx_busy, rx_done, rx_parity_error_flag, rx_framing_error_flag;
	logic [8:0]  rx_char;
	logic [31:0] rd;
	logic [11:0] q[$];
	logic [1:0]  thr, ist, en;
	logic        ad, nine, ovr;
	int          err_total, tests_run, fl;
	int          seed = 32'h75078c4b;
	ursi_top #(.DEPTH(4)) dut (.*);
	ursi_remote_tx tx (.*);
	// ****************************************
	// Clock, reset and bus tasks
	// ****************************************
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	always @(posedge aclk) if (rx_flush) fl++;
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rsp = s_axi_bresp;
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		rsp = s_axi_rresp;
	endtask
	// ****************************************
	// Model comparison
	// ****************************************
	task automatic chk_all;
		logic [31:0] r;
		axr(ursi_pkg::ADDR_STATUS, r);
		`CHK(r[7:4], {thr, ad, 1'b1})
		`CHK(r[1:0], {ovr, q.size() != 0})
		if (q.size() != 0) `CHK(r[3:2], q[0][11:10])
		axr(ursi_pkg::ADDR_IRQ_STAT, r);
		`CHK(r[1:0], ist)
		`CHK(irq, |(ist & en))
	endtask
	// Overrun drops the new character; the buffer is left as it was
	task automatic rx(input int n);
		logic [31:0] r;
		logic [2:0]  lv;
		r = $random(seed);
		tx.send(r[8:0], r[9], r[10], n);
		repeat (3) @(posedge aclk);
		if (ovr || q.size() == 4) begin
			ovr = 1'b1;
			ist[1] = 1'b1;
		end else begin
			q.push_back({r[9], r[10], nine & ad & r[8], r[8:0]});
			lv = 3'(q.size());
			if (!thr[1] || (thr == 2'h3 && lv == 3'h4) || (thr == 2'h2 && lv == 3'h3)) ist[0] = 1'b1;
		end
		chk_all();
	endtask
	task automatic drain(input int m);
		logic [31:0] r;
		repeat (m) begin
			axr(ursi_pkg::ADDR_DATA, r);
			`CHK(r[9:0], q[0][9:0])
			void'(q.pop_front());
			chk_all();
		end
	endtask
	task automatic tally_and_finish;
		if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		err_total++;
		tally_and_finish();
	end
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		{s_axi_wstrb, s_axi_bready, s_axi_rready} = 6'h3f;
		{thr, ist, en, ad, nine, ovr} = 9'h0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		chk_all();
		axw(8'h40, 32'h0);
		`CHK(rsp, ursi_pkg::RESP_SLV)
		axr(8'h40, rd);
		`CHK(rsp, ursi_pkg::RESP_SLV)
		for (int i = 0; i < 4; i++) begin
			thr = 2'(i);
			ad = i[0];
			nine = i[1];
			en = (i == 1) ? 2'h0 : 2'h3;
			axw(ursi_pkg::ADDR_CTRL, {31'h0, nine});
			axw(ursi_pkg::ADDR_STATUS, {24'h0, thr, ad, 5'h0});
			axw(ursi_pkg::ADDR_IRQ_EN, {30'h0, en});
			for (int k = 0; k < 4; k++) begin
				rx(5);
				axw(ursi_pkg::ADDR_IRQ_CLR, 32'h1);
				ist[0] = 1'b0;
			end
			if (i < 3) drain(4);
		end
		rx(5);
		rx(2);
		drain(1);
		axw(ursi_pkg::ADDR_STATUS, 32'h0);
		q.delete();
		{thr, ad, ovr} = 4'h0;
		`CHK(fl > 0, 1'b1)
		chk_all();
		axw(ursi_pkg::ADDR_IRQ_CLR, 32'h3);
		ist = 2'h0;
		fork
			rx(20);
			begin
				repeat (8) @(posedge aclk);
				axr(ursi_pkg::ADDR_STATUS, rd);
				`CHK(rd[4], 1'b0)
			end
		join
		drain(1);
		tally_and_finish();
	end
endmodule
